// ### design/tsi_target.sv
// Ranging sensor I2C register target with power state logic
// What this block does
// - Lines only pulled low or released; idle high
// - Answer only fixed address; run to 1 Mbit/s
// - Bytes eight bits MSB first, then acknowledge
// - Sample on SCL rise; data steady while high
// - Start and stop are SDA edges during SCL high
// - Host frames messages with start and stop/restart
// - Address byte LSB selects write or read
// - Acknowledge own address; keep direction for message
// - Write message: first bytes form 16-bit index
// - Shift data in, acknowledge, store at index
// - Read: load indexed register, shift out on falls
// - Host acknowledges reads; ends by stop or nack
// - Index increments after each data byte
// - Host writes until target nacks or stop
// - Low-power idle keeps registers; I2C disabled
// - Ranging starts only from high-power idle
// - Held in reset until three supplies present
// - Select pin pulse resets I2C logic only
// - Select reset leaves registers and sensor alone
`include "tsi_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module tsi_target (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RST,
  // Two-wire bus
  tsi_if.target            BUS,
  // Supply presence and control pins
  input  wire logic        AVDD_OK,
  input  wire logic        CORE_OK,
  input  wire logic        IOVDD_OK,
  input  wire logic        IF_SELECT,
  input  wire logic        SLEEP_CONTROL_N,
  // Ranging requests from sensor firmware
  input  wire logic        RANGE_START,
  input  wire logic        RANGE_STOP,
  // Status
  output logic [2:0]       POWER_STATE,
  output logic             CORE_IN_RESET,
  // Register write notice
  output logic             REG_WR_STB,
  output logic [15:0]      REG_WR_IDX,
  output logic [7:0]       REG_WR_DATA
);

  localparam logic [6:0] PIN_RST = `TSI_PIN_RST;

  logic [6:0]                pin_raw;
  logic [6:0]                pin_f_reg;
  logic                      scl_f;
  logic                      sda_f;
  logic                      sel_f;
  logic                      sleep_n_f;
  logic                      scl_prev_reg;
  logic                      sda_prev_reg;
  logic                      scl_rise;
  logic                      scl_fall;
  logic                      start_cond;
  logic                      stop_cond;
  logic                      core_rst;
  logic                      i2c_rst;
  tsi_pkg::tsi_tgt_state_t   state_reg;
  tsi_pkg::tsi_pwr_state_t   pwr_reg;
  logic [3:0]                cnt_reg;
  logic [7:0]                sh_reg;
  logic                      dir_reg;
  logic [1:0]                pos_reg;
  logic [15:0]               idx_reg;
  logic                      ack_ok_reg;
  logic                      sda_oe_reg;
  logic [7:0]                mem_reg [`TSI_REG_DEPTH];
  logic [7:0]                rd_data;
  logic                      wr_en;

  // Index decode shared by read and write paths
  function automatic logic idx_mapped(input logic [15:0] idx);
    idx_mapped = (idx[15:`TSI_REG_AW] == '0);
  endfunction : idx_mapped

  // All pins are asynchronous; order matches PIN_RST
  assign pin_raw = {BUS.scl, BUS.sda, IF_SELECT, SLEEP_CONTROL_N,
                    AVDD_OK, CORE_OK, IOVDD_OK};

  // Three-stage synchronisers; level taken when stages two and three agree
  genvar g;
  generate
    for (g = 0; g < 7; g++) begin : g_sync
      logic [2:0] chain_reg;
      always_ff @(posedge CLK) begin
        if (RST) begin
          chain_reg    <= {3{PIN_RST[g]}};
          pin_f_reg[g] <= PIN_RST[g];
        end else begin
          chain_reg <= {chain_reg[1:0], pin_raw[g]};
          if (chain_reg[1] == chain_reg[2]) begin
            pin_f_reg[g] <= chain_reg[2];
          end
        end
      end
    end
  endgenerate

  assign scl_f     = pin_f_reg[6];
  assign sda_f     = pin_f_reg[5];
  assign sel_f     = pin_f_reg[4];
  assign sleep_n_f = pin_f_reg[3];

  // Core stays in reset until every supply is seen
  assign core_rst = RST | ~(&pin_f_reg[2:0]);
  // Select pin high, low-power idle or core reset hold the I2C logic
  assign i2c_rst  = core_rst | sel_f | (pwr_reg == tsi_pkg::PWR_LOW_POWER_IDLE);

  // Previous filtered line levels for edge and condition detection
  always_ff @(posedge CLK) begin
    if (RST) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_prev_reg <= scl_f;
      sda_prev_reg <= sda_f;
    end
  end

  assign scl_rise   = scl_f & ~scl_prev_reg;
  assign scl_fall   = ~scl_f & scl_prev_reg;
  assign start_cond = scl_f & scl_prev_reg & sda_prev_reg & ~sda_f;
  assign stop_cond  = scl_f & scl_prev_reg & ~sda_prev_reg & sda_f;

  assign rd_data = idx_mapped(idx_reg) ? mem_reg[idx_reg[`TSI_REG_AW-1:0]] : `TSI_UNMAPPED_DATA;
  // Data byte lands after its acknowledge bit ends
  assign wr_en   = (state_reg == tsi_pkg::ST_ACK_WR) & scl_fall & (pos_reg == 2'h2);

  // Protocol engine; start and stop override any state
  always_ff @(posedge CLK) begin
    if (i2c_rst) begin
      state_reg  <= tsi_pkg::ST_IDLE;
      cnt_reg    <= 4'h0;
      sh_reg     <= 8'h00;
      dir_reg    <= 1'b0;
      pos_reg    <= 2'h0;
      ack_ok_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else if (start_cond) begin
      state_reg  <= tsi_pkg::ST_ADDR;
      cnt_reg    <= 4'h0;
      sda_oe_reg <= 1'b0;
    end else if (stop_cond) begin
      state_reg  <= tsi_pkg::ST_IDLE;
      sda_oe_reg <= 1'b0;
    end else begin
      case (state_reg)
        tsi_pkg::ST_ADDR: begin
          if (scl_rise) begin
            sh_reg  <= {sh_reg[6:0], sda_f};
            cnt_reg <= cnt_reg + 4'h1;
          end else if (scl_fall && cnt_reg == 4'h8) begin
            if ({sh_reg[7:1], 1'b0} == `TSI_DEV_ADDR) begin
              state_reg  <= tsi_pkg::ST_ACK_ADDR;
              sda_oe_reg <= 1'b1;
              dir_reg    <= sh_reg[0];
            end else begin
              state_reg <= tsi_pkg::ST_IGNORE;
            end
          end
        end
        tsi_pkg::ST_ACK_ADDR: begin
          if (scl_fall) begin
            cnt_reg <= 4'h0;
            pos_reg <= 2'h0;
            if (dir_reg) begin
              sh_reg     <= rd_data;
              sda_oe_reg <= ~rd_data[7];
              state_reg  <= tsi_pkg::ST_RD_BYTE;
            end else begin
              sda_oe_reg <= 1'b0;
              state_reg  <= tsi_pkg::ST_WR_BYTE;
            end
          end
        end
        tsi_pkg::ST_WR_BYTE: begin
          if (scl_rise) begin
            sh_reg  <= {sh_reg[6:0], sda_f};
            cnt_reg <= cnt_reg + 4'h1;
          end else if (scl_fall && cnt_reg == 4'h8) begin
            // Data to an unmapped index is refused so the host stops
            if (pos_reg == 2'h2 && !idx_mapped(idx_reg)) begin
              state_reg <= tsi_pkg::ST_IGNORE;
            end else begin
              state_reg  <= tsi_pkg::ST_ACK_WR;
              sda_oe_reg <= 1'b1;
            end
          end
        end
        tsi_pkg::ST_ACK_WR: begin
          if (scl_fall) begin
            sda_oe_reg <= 1'b0;
            cnt_reg    <= 4'h0;
            state_reg  <= tsi_pkg::ST_WR_BYTE;
            if (pos_reg != 2'h2) begin
              pos_reg <= pos_reg + 2'h1;
            end
          end
        end
        tsi_pkg::ST_RD_BYTE: begin
          if (scl_rise) begin
            cnt_reg <= cnt_reg + 4'h1;
          end else if (scl_fall) begin
            if (cnt_reg == 4'h8) begin
              sda_oe_reg <= 1'b0;
              state_reg  <= tsi_pkg::ST_ACK_RD;
            end else begin
              sh_reg     <= {sh_reg[6:0], 1'b1};
              sda_oe_reg <= ~sh_reg[6];
            end
          end
        end
        tsi_pkg::ST_ACK_RD: begin
          if (scl_rise) begin
            ack_ok_reg <= ~sda_f;
          end else if (scl_fall) begin
            cnt_reg <= 4'h0;
            if (ack_ok_reg) begin
              sh_reg     <= rd_data;
              sda_oe_reg <= ~rd_data[7];
              state_reg  <= tsi_pkg::ST_RD_BYTE;
            end else begin
              state_reg <= tsi_pkg::ST_IGNORE;
            end
          end
        end
        default: begin
          sda_oe_reg <= 1'b0;
        end
      endcase
    end
  end

  // Index survives restarts so a read follows an index-only write
  always_ff @(posedge CLK) begin
    if (i2c_rst) begin
      idx_reg <= `TSI_IDX_RST_VAL;
    end else if (state_reg == tsi_pkg::ST_ACK_WR && scl_fall && !start_cond && !stop_cond) begin
      case (pos_reg)
        2'h0:    idx_reg <= {sh_reg, idx_reg[7:0]};
        2'h1:    idx_reg <= {idx_reg[15:8], sh_reg};
        default: idx_reg <= idx_reg + 16'h0001;
      endcase
    end else if (state_reg == tsi_pkg::ST_RD_BYTE && scl_fall && cnt_reg == 4'h8
                 && !start_cond && !stop_cond) begin
      idx_reg <= idx_reg + 16'h0001;
    end
  end

  // Register storage; only a core reset clears it
  always_ff @(posedge CLK) begin
    if (core_rst) begin
      for (int i = 0; i < `TSI_REG_DEPTH; i++) begin
        mem_reg[i] <= `TSI_REG_RST_VAL;
      end
    end else if (wr_en && !i2c_rst && !start_cond && !stop_cond) begin
      mem_reg[idx_reg[`TSI_REG_AW-1:0]] <= sh_reg;
    end
  end

  // Write notice for the sensor side
  always_ff @(posedge CLK) begin
    if (core_rst) begin
      REG_WR_STB  <= 1'b0;
      REG_WR_IDX  <= 16'h0000;
      REG_WR_DATA <= 8'h00;
    end else begin
      REG_WR_STB <= wr_en && !i2c_rst && !start_cond && !stop_cond;
      if (wr_en) begin
        REG_WR_IDX  <= idx_reg;
        REG_WR_DATA <= sh_reg;
      end
    end
  end

  // Power states; ranging only accepted from high-power idle
  always_ff @(posedge CLK) begin
    if (core_rst) begin
      pwr_reg <= tsi_pkg::PWR_HIGH_POWER_IDLE;
    end else begin
      case (pwr_reg)
        tsi_pkg::PWR_HIGH_POWER_IDLE: begin
          if (!sleep_n_f) begin
            pwr_reg <= tsi_pkg::PWR_LOW_POWER_IDLE;
          end else if (RANGE_START) begin
            pwr_reg <= tsi_pkg::PWR_RANGING;
          end
        end
        tsi_pkg::PWR_LOW_POWER_IDLE: begin
          if (sleep_n_f) begin
            pwr_reg <= tsi_pkg::PWR_HIGH_POWER_IDLE;
          end
        end
        default: begin
          if (RANGE_STOP) begin
            pwr_reg <= tsi_pkg::PWR_HIGH_POWER_IDLE;
          end
        end
      endcase
    end
  end

  // Registered status
  always_ff @(posedge CLK) begin
    if (RST) begin
      CORE_IN_RESET <= 1'b1;
    end else begin
      CORE_IN_RESET <= core_rst;
    end
  end

  assign POWER_STATE  = pwr_reg;
  // Open drain: value always low, enable decides
  assign BUS.t_sda_o  = 1'b0;
  assign BUS.t_sda_oe = sda_oe_reg;

endmodule : tsi_target

`default_nettype wire

// ### design/tsi_regs.svh
// Constants of the ranging sensor I2C target and its host end
`ifndef TSI_REGS_SVH
`define TSI_REGS_SVH

// Bus address byte with the direction bit clear
`define TSI_DEV_ADDR        8'h52
// Register storage: 16-bit index, low part mapped to flip-flops
`define TSI_REG_AW          8
`define TSI_REG_DEPTH       256
`define TSI_REG_RST_VAL     8'h00
`define TSI_UNMAPPED_DATA   8'h00
`define TSI_IDX_RST_VAL     16'h0000
// Pin synchroniser reset levels: scl, sda, sel, sleep_n, supplies x3
`define TSI_PIN_RST         7'h68
// Timing: clock period and one quarter of an SCL bit at 1 Mbit/s
`define TSI_CLK_NS          25
`define TSI_QTR_NS          250
`define TSI_QTR_CYC         ((`TSI_QTR_NS + `TSI_CLK_NS - 1) / `TSI_CLK_NS)

`endif

// ### design/tsi_pkg.sv
// Types shared by the sensor I2C target and host ends
`default_nettype none

package tsi_pkg;

  // Target protocol states
  typedef enum logic [7:0] {
    ST_IDLE     = 8'h01,
    ST_ADDR     = 8'h02,
    ST_ACK_ADDR = 8'h04,
    ST_WR_BYTE  = 8'h08,
    ST_ACK_WR   = 8'h10,
    ST_RD_BYTE  = 8'h20,
    ST_ACK_RD   = 8'h40,
    ST_IGNORE   = 8'h80
  } tsi_tgt_state_t;

  // Sensor power states
  typedef enum logic [2:0] {
    PWR_HIGH_POWER_IDLE = 3'h1,
    PWR_LOW_POWER_IDLE  = 3'h2,
    PWR_RANGING         = 3'h4
  } tsi_pwr_state_t;

  // Host sequencer states
  typedef enum logic [4:0] {
    H_IDLE  = 5'h01,
    H_START = 5'h02,
    H_BYTE  = 5'h04,
    H_PARK  = 5'h08,
    H_STOP  = 5'h10
  } tsi_host_state_t;

endpackage : tsi_pkg

`default_nettype wire

// ### design/tsi_if.sv
// Two-wire bus between the sensor target and its host
`timescale 1ns/10ps
`default_nettype none

interface tsi_if;
  logic scl;
  logic sda;
  logic h_scl_o;
  logic h_scl_oe;
  logic h_sda_o;
  logic h_sda_oe;
  logic t_sda_o;
  logic t_sda_oe;

  // Open-drain wired-AND with external pull-ups; lines idle high
  assign scl = (h_scl_oe & ~h_scl_o) ? 1'b0 : 1'b1;
  assign sda = ((h_sda_oe & ~h_sda_o) | (t_sda_oe & ~t_sda_o)) ? 1'b0 : 1'b1;

  modport target (input scl, input sda, output t_sda_o, output t_sda_oe);
  modport host (input scl, input sda, output h_scl_o, output h_scl_oe,
                output h_sda_o, output h_sda_oe);
endinterface : tsi_if

`default_nettype wire

// ### design/tsi_host.sv
// Host bus controller end: byte sequencer for the sensor I2C target
`include "tsi_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module tsi_host (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RST,
  // Two-wire bus
  tsi_if.host              BUS,
  // Byte command
  input  wire logic        CMD_VALID,
  output logic             CMD_READY,
  input  wire logic        CMD_START,
  input  wire logic        CMD_STOP,
  input  wire logic        CMD_READ,
  input  wire logic        CMD_ACK,
  input  wire logic [7:0]  CMD_DATA,
  // Byte result
  output logic             RSP_VALID,
  output logic [7:0]       RSP_DATA,
  output logic             RSP_ACKED
);

  localparam logic [3:0] QTR_LAST = 4'(`TSI_QTR_CYC - 1);

  tsi_pkg::tsi_host_state_t  state_reg;
  logic [3:0]                qcnt_reg;
  logic [1:0]                phase_reg;
  logic [3:0]                bit_reg;
  logic [7:0]                tx_reg;
  logic                      rd_reg;
  logic                      ack_reg;
  logic                      stop_reg;
  logic                      parked_reg;
  logic [2:0]                sda_chain_reg;
  logic                      sda_f_reg;
  logic                      scl_oe_reg;
  logic                      sda_oe_reg;
  logic                      scl_want;
  logic                      sda_want;
  logic                      tick;

  assign tick      = (qcnt_reg == QTR_LAST);
  assign CMD_READY = (state_reg == tsi_pkg::H_IDLE);

  // SDA from the pin through three stages
  always_ff @(posedge CLK) begin
    if (RST) begin
      sda_chain_reg <= 3'h7;
      sda_f_reg     <= 1'b1;
    end else begin
      sda_chain_reg <= {sda_chain_reg[1:0], BUS.sda};
      if (sda_chain_reg[1] == sda_chain_reg[2]) begin
        sda_f_reg <= sda_chain_reg[2];
      end
    end
  end

  // Pin drive per quarter; SDA moves only while SCL is low, except its fall in start and its release in stop, together with SCL
  always_comb begin
    scl_want = 1'b0;
    sda_want = 1'b0;
    case (state_reg)
      tsi_pkg::H_IDLE: begin
        scl_want = parked_reg;
      end
      tsi_pkg::H_START: begin
        scl_want = (phase_reg == 2'h0) ? parked_reg : (phase_reg == 2'h3);
        sda_want = phase_reg[1];
      end
      tsi_pkg::H_BYTE: begin
        scl_want = ~phase_reg[1];
        if (phase_reg == 2'h0) begin
          sda_want = sda_oe_reg;
        end else if (bit_reg == 4'h8) begin
          sda_want = rd_reg & ack_reg;
        end else begin
          sda_want = ~rd_reg & ~tx_reg[7];
        end
      end
      tsi_pkg::H_PARK: begin
        scl_want = 1'b1;
        sda_want = sda_oe_reg;
      end
      default: begin
        scl_want = ~phase_reg[1];
        sda_want = (phase_reg == 2'h0) ? sda_oe_reg : ~phase_reg[1];
      end
    endcase
  end

  // Registered open-drain enables
  always_ff @(posedge CLK) begin
    if (RST) begin
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else begin
      scl_oe_reg <= scl_want;
      sda_oe_reg <= sda_want;
    end
  end

  // Sequencer: quarter timer, phases, bits and results
  always_ff @(posedge CLK) begin
    if (RST) begin
      state_reg  <= tsi_pkg::H_IDLE;
      qcnt_reg   <= 4'h0;
      phase_reg  <= 2'h0;
      bit_reg    <= 4'h0;
      tx_reg     <= 8'h00;
      rd_reg     <= 1'b0;
      ack_reg    <= 1'b0;
      stop_reg   <= 1'b0;
      parked_reg <= 1'b0;
      RSP_VALID  <= 1'b0;
      RSP_DATA   <= 8'h00;
      RSP_ACKED  <= 1'b0;
    end else begin
      RSP_VALID <= 1'b0;
      if (state_reg == tsi_pkg::H_IDLE) begin
        qcnt_reg  <= 4'h0;
        phase_reg <= 2'h0;
        bit_reg   <= 4'h0;
        if (CMD_VALID) begin
          tx_reg    <= CMD_DATA;
          rd_reg    <= CMD_READ;
          ack_reg   <= CMD_ACK;
          stop_reg  <= CMD_STOP;
          state_reg <= CMD_START ? tsi_pkg::H_START : tsi_pkg::H_BYTE;
        end
      end else if (!tick) begin
        qcnt_reg <= qcnt_reg + 4'h1;
      end else begin
        qcnt_reg  <= 4'h0;
        phase_reg <= phase_reg + 2'h1;
        // Target answers are sampled late in the high phase
        if (state_reg == tsi_pkg::H_BYTE && phase_reg == 2'h3) begin
          if (bit_reg == 4'h8) begin
            RSP_ACKED <= ~sda_f_reg;
            state_reg <= tsi_pkg::H_PARK;
          end else begin
            RSP_DATA <= {RSP_DATA[6:0], sda_f_reg};
            tx_reg   <= {tx_reg[6:0], 1'b0};
          end
          bit_reg <= bit_reg + 4'h1;
        end else if (state_reg == tsi_pkg::H_START && phase_reg == 2'h3) begin
          state_reg <= tsi_pkg::H_BYTE;
        end else if (state_reg == tsi_pkg::H_PARK) begin
          parked_reg <= 1'b1;
          phase_reg  <= 2'h0;
          state_reg  <= stop_reg ? tsi_pkg::H_STOP : tsi_pkg::H_IDLE;
          RSP_VALID  <= ~stop_reg;
        end else if (state_reg == tsi_pkg::H_STOP && phase_reg == 2'h3) begin
          parked_reg <= 1'b0;
          state_reg  <= tsi_pkg::H_IDLE;
          RSP_VALID  <= 1'b1;
        end
      end
    end
  end

  assign BUS.h_scl_o  = 1'b0;
  assign BUS.h_scl_oe = scl_oe_reg;
  assign BUS.h_sda_o  = 1'b0;
  assign BUS.h_sda_oe = sda_oe_reg;

endmodule : tsi_host

`default_nettype wire

// ### sim/tsi_checker.sv
// Bus checker for the sensor target and host ends
`timescale 1ns/10ps
`default_nettype none

module tsi_checker (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Bus lines and drivers
  input wire logic scl,
  input wire logic sda,
  input wire logic h_scl_o,
  input wire logic h_scl_oe,
  input wire logic h_sda_o,
  input wire logic h_sda_oe,
  input wire logic t_sda_o,
  input wire logic t_sda_oe
);
  logic       scl_d_reg;
  logic       sda_d_reg;
  logic [3:0] bits_reg;
  logic [7:0] shift_reg;
  logic [7:0] gap_reg;
  logic       first_reg;
  logic       rd_reg;
  logic       busy_reg;
  logic       rise;
  logic       start;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  // Pin edges; start is the data line falling with the clock high
  assign rise  = scl & ~scl_d_reg;
  assign start = scl & scl_d_reg & sda_d_reg & ~sda;

  // Previous line levels
  always_ff @(posedge CLK) begin
    scl_d_reg <= scl;
    sda_d_reg <= sda;
  end

  // Cycles between clock rises, saturating so idle gaps never wrap
  always_ff @(posedge CLK) begin
    if (RST) begin
      gap_reg <= 8'hFF;
    end else if (rise) begin
      gap_reg <= 8'h00;
    end else if (gap_reg != 8'hFF) begin
      gap_reg <= gap_reg + 8'h01;
    end
  end

  // Open from start until stop
  always_ff @(posedge CLK) begin
    if (RST || (scl && scl_d_reg && !sda_d_reg && sda)) begin
      busy_reg <= 1'b0;
    end else if (start) begin
      busy_reg <= 1'b1;
    end
  end

  // Bit position, address byte and direction of the open message
  always_ff @(posedge CLK) begin
    if (RST) begin
      bits_reg  <= 4'h0;
      first_reg <= 1'b0;
      rd_reg    <= 1'b0;
      shift_reg <= 8'h00;
    end else if (start) begin
      bits_reg  <= 4'h0;
      first_reg <= 1'b1;
    end else if (rise) begin
      shift_reg <= {shift_reg[6:0], sda};
      bits_reg  <= (bits_reg == 4'h8) ? 4'h0 : bits_reg + 4'h1;
      if (bits_reg == 4'h8) begin
        first_reg <= 1'b0;
      end
      if (first_reg && bits_reg == 4'h7) begin
        rd_reg <= sda;
      end
    end
  end

  a_open_drain_only: assert property (!t_sda_o && !h_sda_o && !h_scl_o
    && (busy_reg || start || !(t_sda_oe || h_sda_oe || h_scl_oe)))
    else $error("line driven high");
  a_tgt_stable_high: assert property (scl && $past(scl) |-> $stable(t_sda_oe))
    else $error("target moved data while clock high");
  a_scl_high_width: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high too short");
  a_scl_low_width: assert property ($fell(scl) |-> !scl [*8])
    else $error("clock low too short");
  a_bit_rate_limit: assert property (rise |-> gap_reg >= 8'd39)
    else $error("bit rate too high");
  a_ack_hold: assert property ($rose(t_sda_oe) |-> t_sda_oe [*8])
    else $error("target pull too short");
  a_ack_slot_only: assert property ($rose(t_sda_oe) && (first_reg || !rd_reg) |-> bits_reg == 4'h8)
    else $error("target pulled outside acknowledge slot");
  a_foreign_silent: assert property (first_reg && bits_reg == 4'h8 && shift_reg[7:1] != 7'h29 |-> !t_sda_oe)
    else $error("target answered foreign address");

  c_write_ack: cover property ($rose(t_sda_oe) && !rd_reg);
  c_read_drive: cover property ($rose(t_sda_oe) && rd_reg && !first_reg);
  c_restart: cover property (start && busy_reg);
endmodule : tsi_checker

`default_nettype wire

// ### sim/testbench.sv
// Bench: host end talks to the sensor target over the shared bus
`timescale 1ns/10ps
`default_nettype none

module testbench;
  logic        clk;
  logic        rst;
  logic [2:0]  sup;
  logic        if_sel;
  logic        sleep_n;
  logic        rng_go;
  logic        rng_end;
  logic [2:0]  pwr;
  logic        core_rst;
  logic        wr_stb;
  logic [15:0] wr_idx;
  logic [7:0]  wr_dat;
  logic        c_vld;
  logic        c_rdy;
  logic        c_s;
  logic        c_p;
  logic        c_rd;
  logic        c_ack;
  logic [7:0]  c_dat;
  logic        r_vld;
  logic [7:0]  r_dat;
  logic        r_ack;
  logic [7:0]  got;
  logic        ackd;
  logic [23:0] wr_log [$];
  logic [7:0]  pat [4];
  int          err_total;
  int          check_count;

  tsi_if i_tsi_if ();

  // Both ends on one bus, checker beside it
  tsi_target i_tsi_target (.CLK(clk), .RST(rst), .BUS(i_tsi_if), .AVDD_OK(sup[0]),
    .CORE_OK(sup[1]), .IOVDD_OK(sup[2]), .IF_SELECT(if_sel), .SLEEP_CONTROL_N(sleep_n),
    .RANGE_START(rng_go), .RANGE_STOP(rng_end), .POWER_STATE(pwr), .CORE_IN_RESET(core_rst),
    .REG_WR_STB(wr_stb), .REG_WR_IDX(wr_idx), .REG_WR_DATA(wr_dat));
  tsi_host i_tsi_host (.CLK(clk), .RST(rst), .BUS(i_tsi_if), .CMD_VALID(c_vld),
    .CMD_READY(c_rdy), .CMD_START(c_s), .CMD_STOP(c_p), .CMD_READ(c_rd), .CMD_ACK(c_ack),
    .CMD_DATA(c_dat), .RSP_VALID(r_vld), .RSP_DATA(r_dat), .RSP_ACKED(r_ack));
  tsi_checker i_tsi_checker (.CLK(clk), .RST(rst), .scl(i_tsi_if.scl), .sda(i_tsi_if.sda),
    .h_scl_o(i_tsi_if.h_scl_o), .h_scl_oe(i_tsi_if.h_scl_oe), .h_sda_o(i_tsi_if.h_sda_o),
    .h_sda_oe(i_tsi_if.h_sda_oe), .t_sda_o(i_tsi_if.t_sda_o), .t_sda_oe(i_tsi_if.t_sda_oe));

  // Clock, 25 ns period
  always #12.5 clk = ~clk;

  // Log every register store
  always @(posedge clk) begin
    if (wr_stb === 1'b1) begin
      wr_log.push_back({wr_idx, wr_dat});
    end
  end

  task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] seen);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // Sample between edges, where outputs have settled
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : wt

  // One byte; request held until taken, then wait for the result
  task automatic xfer(input logic s, p, rd, ak, input logic [7:0] d);
    int n;
    @(posedge clk);
    {c_vld, c_s, c_p, c_rd, c_ack, c_dat} <= {1'b1, s, p, rd, ak, d};
    @(negedge clk);
    while (c_rdy !== 1'b1) @(negedge clk);
    @(posedge clk);
    c_vld <= 1'b0;
    n = 0;
    @(negedge clk);
    while (r_vld !== 1'b1 && n < 3000) begin
      n++;
      @(negedge clk);
    end
    if (n >= 3000) chk("response", 24'h1, 24'h0);
    got = r_dat;
    ackd = r_ack;
  endtask : xfer

  task automatic wb(input logic s, p, input logic [7:0] d, input logic ea);
    xfer(s, p, 1'b0, 1'b0, d);
    chk("ack", 24'(ea), 24'(ackd));
  endtask : wb

  task automatic rb(input logic s, p, ak, input logic [7:0] e);
    xfer(s, p, 1'b1, ak, 8'hFF);
    chk("data", 24'(e), 24'(got));
  endtask : rb

  // Open a write message and send the index, leaving it open
  task automatic seti(input logic [15:0] idx);
    wb(1'b1, 1'b0, 8'h52, 1'b1);
    wb(1'b0, 1'b0, idx[15:8], 1'b1);
    wb(1'b0, 1'b0, idx[7:0], 1'b1);
  endtask : seti

  task automatic rd_at(input logic [15:0] idx, input logic [7:0] e);
    seti(idx);
    wb(1'b1, 1'b0, 8'h53, 1'b1);
    rb(1'b0, 1'b1, 1'b0, e);
  endtask : rd_at

  task automatic rng(input logic go, input logic en);
    @(posedge clk);
    {rng_go, rng_end} <= {go, en};
    @(posedge clk);
    {rng_go, rng_end} <= 2'b00;
    wt(4);
  endtask : rng

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize

  // Hang guard, well beyond the expected run
  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    $display("Error run expected end seen hang");
    summarize();
  end

  initial begin
    {clk, rst, sup, if_sel, sleep_n, rng_go, rng_end} = 9'b0_1_000_0_1_0_0;
    {c_vld, c_s, c_p, c_rd, c_ack, c_dat} = 13'h0000;
    {err_total, check_count} = 64'h0;
    pat = '{8'hA5, 8'h3C, 8'hF0, 8'h0F};
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    // Supplies arrive one by one; core waits for the last
    for (int i = 0; i < 3; i++) begin
      wt(8);
      chk("core held", 24'h1, 24'(core_rst));
      @(posedge clk);
      sup <= {sup[1:0], 1'b1};
    end
    wt(8);
    chk("core free", 24'h0, 24'(core_rst));
    chk("power up", 24'(tsi_pkg::PWR_HIGH_POWER_IDLE), 24'(pwr));
    $display("test supplies done");
    // Sequential write, stop after the last byte
    seti(16'h0010);
    for (int i = 0; i < 4; i++) wb(1'b0, i == 3, pat[i], 1'b1);
    wt(4);
    chk("stores", 24'h4, 24'(wr_log.size()));
    for (int i = 0; i < 4; i++) chk("st", {16'h0010 + 16'(i), pat[i]}, wr_log[i]);
    // Random read, last byte refused; next message resumes the index
    seti(16'h0010);
    wb(1'b1, 1'b0, 8'h53, 1'b1);
    for (int i = 0; i < 3; i++) rb(1'b0, i == 2, i != 2, pat[i]);
    wb(1'b1, 1'b0, 8'h53, 1'b1);
    rb(1'b0, 1'b1, 1'b0, pat[3]);
    $display("test write read done");
    // Foreign addresses of both directions stay unanswered
    for (int i = 0; i < 4; i++) wb(1'b1, 1'b1, 8'h52 ^ (8'h03 << i), 1'b0);
    // Unmapped index refuses data and stores nothing
    seti(16'h0100);
    wb(1'b0, 1'b1, 8'h77, 1'b0);
    chk("no store", 24'h4, 24'(wr_log.size()));
    $display("test refusals done");
    // Interface reset in mid-message clears index, keeps registers
    seti(16'h0011);
    @(posedge clk);
    if_sel <= 1'b1;
    wt(8);
    @(posedge clk);
    if_sel <= 1'b0;
    wt(8);
    wb(1'b1, 1'b0, 8'h53, 1'b1);
    rb(1'b0, 1'b1, 1'b0, 8'h00);
    rd_at(16'h0011, pat[1]);
    $display("test interface reset done");
    // Low-power idle: bus silent, no ranging, contents kept
    @(posedge clk);
    sleep_n <= 1'b0;
    wt(8);
    chk("sleep", 24'(tsi_pkg::PWR_LOW_POWER_IDLE), 24'(pwr));
    wb(1'b1, 1'b1, 8'h52, 1'b0);
    rng(1'b1, 1'b0);
    chk("no range", 24'(tsi_pkg::PWR_LOW_POWER_IDLE), 24'(pwr));
    @(posedge clk);
    sleep_n <= 1'b1;
    wt(8);
    chk("wake", 24'(tsi_pkg::PWR_HIGH_POWER_IDLE), 24'(pwr));
    rd_at(16'h0012, pat[2]);
    rng(1'b1, 1'b0);
    chk("ranging", 24'(tsi_pkg::PWR_RANGING), 24'(pwr));
    rng(1'b0, 1'b1);
    chk("range end", 24'(tsi_pkg::PWR_HIGH_POWER_IDLE), 24'(pwr));
    $display("test power done");
    // Losing one supply resets the core and its registers
    @(posedge clk);
    sup <= 3'h5;
    wt(8);
    chk("core lost", 24'h1, 24'(core_rst));
    @(posedge clk);
    sup <= 3'h7;
    wt(12);
    rd_at(16'h0010, 8'h00);
    $display("test supply loss done");
    summarize();
  end
endmodule : testbench

`default_nettype wire
